//--- shared/fts_pkg.sv
// Constants, types and the register map of the framed ten-bit serializer.
// Assumes a single bus clock; reference-clock counts are in reference periods.
`default_nettype none

package fts_pkg;

   localparam int WORD_W     = 10;
   localparam int FRAME_W    = 12;
   localparam int BURST_LEN  = 1024;
   localparam int QUAL_CYC   = 6;
   localparam int LOCK_CYC   = 2049;
   localparam int BIT_DIV    = 1;
   localparam int BURST_W    = 11;
   localparam int LOCK_W     = 12;
   localparam int BUF_DEPTH  = 2;

   // Six ones then six zeros, sent bit 0 first
   localparam logic [FRAME_W-1:0] SYNC_PAT = 12'h03F;

   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;

   localparam int CTRL_SYNC_BIT = 0;
   localparam int ST_LOCK_BIT   = 0;
   localparam int ST_SYNC_BIT   = 1;
   localparam int ST_OE_BIT     = 2;
   localparam int ST_LVL_LSB    = 4;
   localparam int ST_BURST_LSB  = 16;

   localparam logic CTRL_RESET = 1'b0;

   typedef enum logic [2:0] {ST_DOWN, ST_LOCK, ST_DATA, ST_BURST, ST_HOLD} fts_state_e;

   typedef struct packed {
      logic ref_clk;
      logic edge_sel;
      logic sync_a;
      logic sync_b;
      logic en;
      logic pd_n;
   } fts_pins_s;

endpackage

`default_nettype wire

//--- rtl/fts_pair_buffer.sv
// Small word FIFO with valid and ready on both sides.
// Assumes the filler holds data while in_ready is low.
`timescale 1ns/1ns
`default_nettype none

module fts_pair_buffer #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 2
)(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH+1)-1:0]      level
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = cnt_q != CNT_W'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rd_q];
   assign level     = cnt_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push)
      begin
         mem_d[wr_q] = in_data;
         wr_d = (wr_q == PTR_W'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
         rd_d = (rd_q == PTR_W'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_q[i] <= '0;
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

endmodule // fts_pair_buffer

`default_nettype wire

//--- rtl/fts_serializer.sv
// Framed ten-bit serializer: pins sampled on pclk, APB control and status.
// Assumes the reference clock is slow enough for twelve bit slots per period.
// Notes on behaviour
// - Two sync request inputs are ORed.
// - Six reference cycles high start 1024 sync patterns.
// - Request still high after burst keeps sync going.
// - Started burst ignores request toggling until done.
// - Selected strobe edge captures ten-bit word.
// - Edge select high rising, low falling.
// - Reference clock paces lock and strobes data.
// - Output enable low puts output high impedance.
// - Power-down low forces high impedance.
// - Sync pattern is six ones, six zeros.
// - Data frame: start one, word, stop zero.
// - High impedance until lock, 2049 reference cycles.
// - Sync mode discards parallel data.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module fts_serializer
   import fts_pkg::*;
#(
   parameter int BIT_DIV_P = BIT_DIV
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              reference_clock_in,
   input  wire logic              strobe_edge_select,
   input  wire logic [WORD_W-1:0] parallel_word_in,
   input  wire logic              sync_req_a,
   input  wire logic              sync_req_b,
   input  wire logic              out_enable,
   input  wire logic              power_down_n,
   output logic                   serial_out_p,
   output logic                   serial_out_n,
   output logic                   serial_out_oe
);

   fts_pins_s         pin_s1_q, pin_s2_q, pin_s3_q, pin_s1_d, pin_s2_d, pin_s3_d;
   logic [WORD_W-1:0] word_s1_q, word_s2_q, word_s3_q, word_s1_d, word_s2_d, word_s3_d;

   fts_state_e        state_q, state_d;
   logic [LOCK_W-1:0] lock_cnt_q, lock_cnt_d;
   logic [2:0]        qual_cnt_q, qual_cnt_d;
   logic [BURST_W-1:0] burst_cnt_q, burst_cnt_d;
   logic              sync_pend_q, sync_pend_d;
   logic [WORD_W-1:0] hold_q, hold_d;
   logic              hold_v_q, hold_v_d;
   logic [FRAME_W-1:0] sh_q, sh_d;
   logic [3:0]        bits_q, bits_d;
   logic [7:0]        div_q, div_d;
   logic              out_p_q, out_p_d, out_n_q, out_n_d, oe_q, oe_d;
   logic              ctrl_sync_q, ctrl_sync_d;
   logic [31:0]       prdata_q, prdata_d, stat_w;
   logic              pready_q, pready_d, pslverr_q, pslverr_d;

   logic              ref_rise, ref_fall, strobe, req, sync_mode, bit_en, slot_free;
   logic              load_sync, load_data, buf_pop, buf_in_rdy, buf_v, setup, wr_ctrl;
   logic [WORD_W-1:0] buf_word;
   logic [1:0]        buf_lvl;

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign serial_out_p  = out_p_q;
   assign serial_out_n  = out_n_q;
   assign serial_out_oe = oe_q;

   // Edges only from the synchronized second and third stages
   assign ref_rise  = pin_s2_q.ref_clk && !pin_s3_q.ref_clk;
   assign ref_fall  = !pin_s2_q.ref_clk && pin_s3_q.ref_clk;
   assign strobe    = pin_s3_q.edge_sel ? ref_rise : ref_fall;
   assign req       = pin_s3_q.sync_a || pin_s3_q.sync_b || ctrl_sync_q;
   assign sync_mode = (state_q == ST_BURST) || (state_q == ST_HOLD);
   assign bit_en    = div_q == '0;
   assign slot_free = bit_en && (bits_q == '0);
   assign load_sync = slot_free && sync_mode && sync_pend_q;
   assign load_data = slot_free && (state_q == ST_DATA) && buf_v;
   // Words queued before a sync burst are flushed, not sent
   assign buf_pop   = load_data || (sync_mode && buf_v);
   assign setup     = psel && !penable;
   assign wr_ctrl   = psel && penable && pready_q && pwrite && (paddr == CTRL_OFS);

   fts_pair_buffer #(
      .WIDTH (WORD_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk       (pclk),
      .rst_n     (presetn),
      .in_valid  (hold_v_q),
      .in_ready  (buf_in_rdy),
      .in_data   (hold_q),
      .out_valid (buf_v),
      .out_ready (buf_pop),
      .out_data  (buf_word),
      .level     (buf_lvl)
   );

   always_comb
   begin
      pin_s1_d  = {reference_clock_in, strobe_edge_select, sync_req_a, sync_req_b,
                   out_enable, power_down_n};
      pin_s2_d  = pin_s1_q;
      pin_s3_d  = pin_s2_q;
      word_s1_d = parallel_word_in;
      word_s2_d = word_s1_q;
      word_s3_d = word_s2_q;
   end

   always_comb
   begin
      state_d     = state_q;
      lock_cnt_d  = lock_cnt_q;
      qual_cnt_d  = qual_cnt_q;
      burst_cnt_d = burst_cnt_q;
      hold_d      = hold_q;
      hold_v_d    = hold_v_q;
      sh_d        = sh_q;
      bits_d      = bits_q;
      out_p_d     = out_p_q;
      div_d       = bit_en ? 8'(BIT_DIV_P - 1) : div_q - 1'b1;
      sync_pend_d = ref_rise ? 1'b1 : ((load_sync || !sync_mode) ? 1'b0 : sync_pend_q);

      unique case (state_q)
         ST_DOWN:
         begin
            lock_cnt_d = '0;
            state_d    = ST_LOCK;
         end
         ST_LOCK:
            if (ref_rise)
            begin
               if (lock_cnt_q == LOCK_W'(LOCK_CYC - 1))
                  state_d = ST_DATA;
               else
                  lock_cnt_d = lock_cnt_q + 1'b1;
            end
         ST_DATA:
            if (!req)
               qual_cnt_d = '0;
            else if (ref_rise)
            begin
               if (qual_cnt_q == 3'(QUAL_CYC - 1))
               begin
                  state_d     = ST_BURST;
                  qual_cnt_d  = '0;
                  burst_cnt_d = '0;
               end
               else
                  qual_cnt_d = qual_cnt_q + 1'b1;
            end
         ST_BURST:
            // Request level is not looked at until the last pattern
            if (load_sync)
            begin
               if (burst_cnt_q == BURST_W'(BURST_LEN - 1))
                  state_d = req ? ST_HOLD : ST_DATA;
               else
                  burst_cnt_d = burst_cnt_q + 1'b1;
            end
         ST_HOLD:
            if (!req)
               state_d = ST_DATA;
      endcase

      // Latest strobe wins; an unpushed older word is overwritten
      if (strobe && state_q == ST_DATA)
      begin
         hold_d   = word_s3_q;
         hold_v_d = 1'b1;
      end
      else if (hold_v_q && (buf_in_rdy || state_q != ST_DATA))
         hold_v_d = 1'b0;

      if (bit_en && bits_q != '0)
      begin
         out_p_d = sh_q[0];
         sh_d    = sh_q >> 1;
         bits_d  = bits_q - 1'b1;
      end
      else if (load_sync)
      begin
         out_p_d = SYNC_PAT[0];
         sh_d    = SYNC_PAT >> 1;
         bits_d  = 4'(FRAME_W - 1);
      end
      else if (load_data)
      begin
         out_p_d = 1'b1;
         sh_d    = {1'b0, 1'b0, buf_word};
         bits_d  = 4'(FRAME_W - 1);
      end

      if (!pin_s3_q.pd_n)
      begin
         state_d  = ST_DOWN;
         bits_d   = '0;
         hold_v_d = 1'b0;
      end

      out_n_d = !out_p_d;
      // Enable path never touches frame timing, only the driver
      oe_d    = pin_s3_q.en && pin_s3_q.pd_n && (state_q != ST_DOWN)
                && (state_q != ST_LOCK);
   end

   always_comb
   begin
      stat_w                             = '0;
      stat_w[ST_LOCK_BIT]                = (state_q != ST_DOWN) && (state_q != ST_LOCK);
      stat_w[ST_SYNC_BIT]                = sync_mode;
      stat_w[ST_OE_BIT]                  = oe_q;
      stat_w[ST_LVL_LSB +: 2]            = buf_lvl;
      stat_w[ST_BURST_LSB +: BURST_W]    = burst_cnt_q;
      ctrl_sync_d = wr_ctrl ? pwdata[CTRL_SYNC_BIT] : ctrl_sync_q;
      pready_d    = setup;
      pslverr_d   = setup && (paddr != CTRL_OFS) && (paddr != STAT_OFS);
      prdata_d    = '0;
      if (setup && !pwrite && paddr == CTRL_OFS)
         prdata_d[CTRL_SYNC_BIT] = ctrl_sync_q;
      else if (setup && !pwrite && paddr == STAT_OFS)
         prdata_d = stat_w;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
         word_s1_q <= '0;
         word_s2_q <= '0;
         word_s3_q <= '0;
      end
      else
      begin
         pin_s1_q <= pin_s1_d;
         pin_s2_q <= pin_s2_d;
         pin_s3_q <= pin_s3_d;
         word_s1_q <= word_s1_d;
         word_s2_q <= word_s2_d;
         word_s3_q <= word_s3_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q     <= ST_DOWN;
         lock_cnt_q  <= '0;
         qual_cnt_q  <= '0;
         burst_cnt_q <= '0;
         sync_pend_q <= 1'b0;
         hold_q      <= '0;
         hold_v_q    <= 1'b0;
         sh_q        <= '0;
         bits_q      <= '0;
         div_q       <= '0;
         out_p_q     <= 1'b0;
         out_n_q     <= 1'b1;
         oe_q        <= 1'b0;
         ctrl_sync_q <= CTRL_RESET;
         prdata_q    <= '0;
         pready_q    <= 1'b0;
         pslverr_q   <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         lock_cnt_q  <= lock_cnt_d;
         qual_cnt_q  <= qual_cnt_d;
         burst_cnt_q <= burst_cnt_d;
         sync_pend_q <= sync_pend_d;
         hold_q      <= hold_d;
         hold_v_q    <= hold_v_d;
         sh_q        <= sh_d;
         bits_q      <= bits_d;
         div_q       <= div_d;
         out_p_q     <= out_p_d;
         out_n_q     <= out_n_d;
         oe_q        <= oe_d;
         ctrl_sync_q <= ctrl_sync_d;
         prdata_q    <= prdata_d;
         pready_q    <= pready_d;
         pslverr_q   <= pslverr_d;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_or_request: assert property (state_q == ST_DATA && ref_rise && pin_s3_q.pd_n
      && qual_cnt_q == 3'(QUAL_CYC - 1) && (pin_s3_q.sync_a || pin_s3_q.sync_b)
      |=> state_q == ST_BURST) else $error("sync input did not start burst");
   a_burst_entry: assert property ((state_q == ST_DATA ##1 state_q == ST_BURST)
      |-> $past(qual_cnt_q) == 3'(QUAL_CYC - 1)) else $error("burst without six cycles");
   a_hold_sync: assert property (state_q == ST_HOLD && req && pin_s3_q.pd_n
      |=> state_q == ST_HOLD) else $error("sync stopped while requested");
   a_burst_keep: assert property (state_q == ST_BURST && pin_s3_q.pd_n
      && burst_cnt_q != BURST_W'(BURST_LEN - 1) |=> state_q == ST_BURST)
      else $error("burst cut short");
   a_word_capture: assert property (strobe && state_q == ST_DATA && pin_s3_q.pd_n
      |=> hold_v_q && hold_q == $past(word_s3_q)) else $error("word not captured");
   a_edge_select: assert property (ref_rise && !pin_s3_q.edge_sel && !hold_v_q
      |=> !hold_v_q) else $error("captured on wrong edge");
   a_lock_pace: assert property (state_q == ST_LOCK && !ref_rise && pin_s3_q.pd_n
      |=> lock_cnt_q == $past(lock_cnt_q)) else $error("lock counted without reference");
   a_en_hiz: assert property (!pin_s3_q.en |=> !oe_q)
      else $error("driving while disabled");
   a_pd_hiz: assert property (!pin_s3_q.pd_n |=> !oe_q && state_q == ST_DOWN)
      else $error("driving in power-down");
   a_sync_pattern: assert property (load_sync && BIT_DIV_P == 1
      |=> out_p_q ##5 out_p_q ##1 !out_p_q) else $error("bad sync pattern");
   a_start_bit: assert property (load_data && pin_s3_q.pd_n |=> out_p_q && bits_q == 4'(FRAME_W - 1))
      else $error("frame lacks start bit");
   a_lock_hiz: assert property (state_q == ST_LOCK || state_q == ST_DOWN |=> !oe_q)
      else $error("driving before lock");
   a_sync_drop: assert property (sync_mode && !hold_v_q |=> !hold_v_q)
      else $error("data captured in sync mode");
   a_bit_step: assert property (bit_en && bits_q != '0 && pin_s3_q.pd_n
      |=> bits_q == $past(bits_q) - 1'b1) else $error("bit slot skipped");

endmodule // fts_serializer

`default_nettype wire

//--- tb/fts_rx_model.sv
// Remote receiver model: decodes data and sync frames from the serial line.
// Assumes one bit per pclk and a line that is only valid while oe is high.
`timescale 1ns/1ns
`default_nettype none

module fts_rx_model
   import fts_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              line_p,
   input  wire logic              line_n,
   input  wire logic              line_oe,
   input  wire logic              sync_cmd,
   output logic                   sync_req_b,
   output logic                   word_stb,
   output logic [WORD_W-1:0]      word,
   output logic [15:0]            sync_cnt,
   output logic [15:0]            bad_cnt
);
   logic [FRAME_W-1:0] sh;
   logic               prev;
   int                 n;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         n = 0;
         prev = 1'b1;
         sh = '0;
         sync_req_b <= 1'b0;
         word_stb <= 1'b0;
         word <= '0;
         sync_cnt <= 16'h0000;
         bad_cnt <= 16'h0000;
      end
      else
      begin
         word_stb <= 1'b0;
         sync_req_b <= sync_cmd;
         if (line_oe !== 1'b1)
         begin
            // Released line carries nothing; demand a low bit before hunting again
            n = 0;
            prev = 1'b1;
         end
         else
         begin
            if (line_n !== ~line_p)
               bad_cnt <= bad_cnt + 16'h0001;
            if (n == 0 && line_p === 1'b1 && prev === 1'b0)
            begin
               sh[0] = 1'b1;
               n = 1;
            end
            else if (n > 0)
            begin
               sh[n] = line_p;
               n++;
               if (n == FRAME_W)
               begin
                  n = 0;
                  if (sh === SYNC_PAT)
                     sync_cnt <= sync_cnt + 16'h0001;
                  else if (sh[FRAME_W-1] === 1'b0)
                  begin
                     word_stb <= 1'b1;
                     word <= sh[WORD_W:1];
                  end
                  else
                     bad_cnt <= bad_cnt + 16'h0001;
               end
            end
            prev = line_p;
         end
      end
   end
endmodule // fts_rx_model

`default_nettype wire

//--- tb/tb_fts_serializer.sv
// Bench for the framed ten-bit serializer: pins, APB and the receiver model.
// Assumes a reference period of 16 pclk and the default bit divider.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("MISMATCH at %0t: got %0h expected %0h", $time, (g), (e)); \
      end \
   end

module tb_fts_serializer
   import fts_pkg::*;
;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              ref_clk, edge_sel, sync_a, out_en, pd_n, sync_cmd, sync_b;
   logic              sp, sn, soe, wstb;
   logic [WORD_W-1:0] pword, wrx, w;
   logic [15:0]       sync_cnt, bad_cnt, s0;
   logic [3:0]        ph = 4'h0;
   int                refcnt = 0, cycles = 0, mismatches = 0, tests_run = 0;
   logic [WORD_W-1:0] feed[$], exp_q[$], rcv_q[$];

   fts_serializer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reference_clock_in(ref_clk), .strobe_edge_select(edge_sel),
      .parallel_word_in(pword), .sync_req_a(sync_a), .sync_req_b(sync_b),
      .out_enable(out_en), .power_down_n(pd_n), .serial_out_p(sp), .serial_out_n(sn),
      .serial_out_oe(soe));

   fts_rx_model rx_u (.pclk(pclk), .presetn(presetn), .line_p(sp), .line_n(sn),
      .line_oe(soe), .sync_cmd(sync_cmd), .sync_req_b(sync_b), .word_stb(wstb),
      .word(wrx), .sync_cnt(sync_cnt), .bad_cnt(bad_cnt));

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic final_report();
      $display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Reference clock, word feed at mid-phase, receiver capture and the run ceiling
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      ph <= ph + 4'h1;
      ref_clk <= ~ph[3];
      if (ph == 4'hF)
         refcnt <= refcnt + 1;
      if (ph == 4'h4 && feed.size() > 0)
      begin
         pword <= feed[0];
         exp_q.push_back(feed.pop_front());
      end
      else if (cycles == 0)
         pword <= 10'h000;
      if (wstb === 1'b1)
         rcv_q.push_back(wrx);
      if (cycles == 90000)
      begin
         mismatches++;
         final_report();
      end
   end

   task automatic wait_ref(input int n);
      int t;
      t = refcnt + n;
      while (refcnt < t)
         @(posedge pclk);
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // No local limit: a slave that never answers runs into the run ceiling
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_sync_end();
      int k;
      for (k = 0; k < 4000; k++)
      begin
         apb(1'b0, STAT_OFS, 32'h0);
         if (rd[ST_SYNC_BIT] === 1'b0)
            break;
      end
   endtask

   // Never repeat the previous word, and skip the one word that looks like a sync frame
   function automatic logic [WORD_W-1:0] rnd_word(input logic [WORD_W-1:0] prev);
      logic [WORD_W-1:0] v;
      v = prev;
      while (v === prev || v === 10'h01F)
         v = WORD_W'($urandom());
      return v;
   endfunction

   task automatic check_stream();
      int i, k;
      i = 0;
      while (i < rcv_q.size() && rcv_q[i] !== exp_q[0])
         i++;
      `CHK(i < rcv_q.size(), 1'b1)
      for (k = 0; k < exp_q.size(); k++)
         `CHK((i + k < rcv_q.size()) ? rcv_q[i+k] : ~exp_q[k], exp_q[k])
   endtask

   initial
   begin
      int n, es;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      edge_sel = 1'b1;
      sync_a = 1'b0;
      sync_cmd = 1'b0;
      out_en = 1'b1;
      pd_n = 1'b1;
      void'($urandom(9));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0);
      `CHK(rd, 32'h00000000)
      apb(1'b1, CTRL_OFS, 32'h1);
      apb(1'b0, CTRL_OFS, 32'h0);
      `CHK(rd[CTRL_SYNC_BIT], 1'b1)
      apb(1'b1, CTRL_OFS, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, STAT_OFS, 32'hFFFFFFFF);
      apb(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[ST_LOCK_BIT], 1'b0)
      $display("Test registers finished");
      wait_ref(2040);
      `CHK(soe, 1'b0)
      n = 0;
      while (soe !== 1'b1 && n < 400)
      begin
         @(posedge pclk);
         n++;
      end
      `CHK(soe, 1'b1)
      apb(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[ST_LOCK_BIT], 1'b1)
      $display("Test lock finished");
      w = pword;
      for (es = 1; es >= 0; es--)
      begin
         edge_sel <= es[0];
         wait_ref(3);
         rcv_q.delete();
         exp_q.delete();
         repeat (16)
         begin
            w = rnd_word(w);
            feed.push_back(w);
         end
         wait_ref(22);
         check_stream();
         $display("Test data edge %0d finished", es);
      end
      s0 = sync_cnt;
      sync_a <= 1'b1;
      wait_ref(3);
      sync_a <= 1'b0;
      wait_ref(10);
      `CHK(sync_cnt, s0)
      s0 = sync_cnt;
      sync_a <= 1'b1;
      wait_ref(8);
      sync_a <= 1'b0;
      wait_ref(20);
      n = rcv_q.size();
      apb(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[ST_SYNC_BIT], 1'b1)
      wait_ref(80);
      sync_a <= 1'b1;
      wait_ref(3);
      sync_a <= 1'b0;
      wait_ref(800);
      `CHK(rcv_q.size(), n)
      wait_sync_end();
      wait_ref(3);
      `CHK(16'(sync_cnt - s0), 16'(BURST_LEN))
      $display("Test burst finished");
      s0 = sync_cnt;
      sync_cmd <= 1'b1;
      wait_ref(1100);
      sync_cmd <= 1'b0;
      wait_sync_end();
      wait_ref(3);
      `CHK((sync_cnt - s0) > 16'd1080 && (sync_cnt - s0) < 16'd1105, 1'b1)
      $display("Test held sync finished");
      // Checked before the enable toggle: a mid-frame release may misalign the receiver
      `CHK(bad_cnt, 16'h0000)
      out_en <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK(soe, 1'b0)
      out_en <= 1'b1;
      repeat (8) @(posedge pclk);
      `CHK(soe, 1'b1)
      pd_n <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK(soe, 1'b0)
      apb(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[ST_LOCK_BIT], 1'b0)
      pd_n <= 1'b1;
      wait_ref(100);
      `CHK(soe, 1'b0)
      $display("Test power finished");
      final_report();
   end
endmodule // tb_fts_serializer

`default_nettype wire
